// [rtl/asr_pkg.sv]
// Constants and types shared by the analog-select and reset input logic
package asr_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ        = 100000;
  localparam int RS_MIN_MS      = 12;
  localparam int ALARM_MAX_MS   = 30;
  localparam int PANEL_HOLD_MS  = 4000;
  localparam int DEBOUNCE_MS    = 1;
  localparam int RS_MIN_CYC     = RS_MIN_MS * CLK_KHZ;
  localparam int ALARM_MAX_CYC  = ALARM_MAX_MS * CLK_KHZ;
  localparam int PANEL_HOLD_CYC = PANEL_HOLD_MS * CLK_KHZ;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
  localparam int RESET_SEQ_CYC  = 16;
  // ==========================================================
  // Terminals and function codes
  localparam int         NUM_TERM      = 5;
  localparam int         FN_W          = 5;
  localparam int         NUM_PIN       = NUM_TERM + 2;
  localparam logic [4:0] FN_ANALOG_SEL = 5'h10;
  localparam logic [4:0] FN_RESET      = 5'h12;
  // ==========================================================
  // Register map
  localparam int         ADDR_W       = 5;
  localparam logic [4:0] REG_TERM_FUNC = 5'h00;
  localparam logic [4:0] REG_TERM_NC   = 5'h04;
  localparam logic [4:0] REG_SETTINGS  = 5'h08;
  localparam logic [4:0] REG_STATUS    = 5'h0c;
  localparam logic [4:0] REG_IRQ_STAT  = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK  = 5'h14;
  // Terminal five defaults to reset so a held contact is seen at power-up
  localparam logic [24:0] TERM_FUNC_RST = 25'h1200000;
  localparam logic [4:0]  TERM_NC_RST   = 5'h00;
  localparam logic [7:0]  SETTINGS_RST  = 8'h10;
  // ==========================================================
  // Settings fields
  localparam int         SET_PAIR_LSB    = 0;
  localparam int         SET_POL_LSB     = 2;
  localparam int         SET_FSRC_LSB    = 4;
  localparam int         SET_EDGE_BIT    = 6;
  localparam int         SET_RESTART_BIT = 7;
  localparam logic [1:0] PAIR_CURRENT    = 2'h0;
  localparam logic [1:0] PAIR_VOLT2      = 2'h1;
  localparam logic [1:0] POL_UNIPOLAR    = 2'h0;
  localparam logic [1:0] FSRC_ANALOG     = 2'h1;
  // ==========================================================
  // Interrupt bits
  localparam int IRQ_W          = 4;
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_PANEL_ERR  = 1;
  localparam int IRQ_NC_REFUSED = 2;
  localparam int IRQ_TRIP       = 3;
  // ==========================================================
  // Types
  typedef struct packed {
    logic current;
    logic volt2;
    logic volt1;
    logic bipolar;
  } asr_analog_sel_t;
  typedef enum {ST_IDLE, ST_HELD, ST_WAIT_REL, ST_SEQ} asr_rs_state_t;
endpackage

// [rtl/asr_debounce.sv]
// Two-flop synchroniser and debounce filter for terminal inputs
`timescale 1ns/1ps
module asr_debounce #(
  parameter int WIDTH = 7,
  parameter int CYC   = 100000
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  localparam int CW = $clog2(CYC + 1);
  logic [WIDTH-1:0] sync_q1;
  logic [WIDTH-1:0] sync_q2;
  logic [CW-1:0]    cnt [WIDTH];
  // ==========================================================
  // Synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q1 <= '0;
      sync_q2 <= '0;
    end else begin
      sync_q1 <= din;
      sync_q2 <= sync_q1;
    end
  end
  // ==========================================================
  // Stable-level filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
      for (int i = 0; i < WIDTH; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync_q2[i] == dout[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] == CW'(CYC - 1)) begin
          cnt[i]  <= '0;
          dout[i] <= sync_q2[i];
        end else begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/asr_hold_timer.sv]
// Saturating hold timer that flags a level held for a set time
`timescale 1ns/1ps
module asr_hold_timer #(
  parameter int CYC = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;
  // ==========================================================
  // Counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (cnt != CW'(CYC)) begin
      cnt <= cnt + 1'b1;
    end
  end
  assign done = run && (cnt == CW'(CYC));
endmodule

// [rtl/asr_top.sv]
// Analog input select and drive reset terminal logic
//
// Summary of operation
// - Either function may sit on any of five terminals via its code.
// - Select active with pair setting 00 enables the current input.
// - Select active with pair setting 01 enables second voltage pair.
// - Select inactive always uses the primary voltage pair.
// - Polarity setting decides whether the analog signal is bipolar.
// - Current input is never bipolar; direction from command inputs.
// - Reset turns motor output off, clears trip, applies power-up reset.
// - Reset runs only after the contact stays on for the minimum pulse time.
// - Alarm output drops within 30 ms of reset onset.
// - Motor restarts at once if run is active and the contact is off when reset completes.
// - Edge setting picks leading or trailing reset edge as active.
// - Reset terminal accepts normally-open polarity only.
// - Power-up performs the same reset operation as a reset pulse.
// - Reset held over 4 s from power-up flags panel error, no fault.
// - Panel error clears after reset release then an operator key.
`timescale 1ns/1ps
module asr_top
  import asr_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = asr_pkg::DEBOUNCE_CYC,
  parameter int RS_MIN_CYCLES   = asr_pkg::RS_MIN_CYC,
  parameter int ALARM_CYCLES    = asr_pkg::ALARM_MAX_CYC,
  parameter int PANEL_CYCLES    = asr_pkg::PANEL_HOLD_CYC,
  parameter int SEQ_CYCLES      = asr_pkg::RESET_SEQ_CYC
) (
  input  wire logic                            CLK,
  input  wire logic                            RST_N,
  input  wire logic [asr_pkg::NUM_TERM-1:0]    TERM_IN,
  input  wire logic                            FWD_CMD_IN,
  input  wire logic                            REV_CMD_IN,
  input  wire logic                            RUN_CMD,
  input  wire logic                            TRIP_EVENT,
  input  wire logic                            ANALOG_NEG,
  input  wire logic                            KEY_PRESS,
  input  wire logic [asr_pkg::ADDR_W-1:0]      ADDR,
  input  wire logic [31:0]                     WDATA,
  input  wire logic                            WR,
  input  wire logic                            RD,
  output logic      [31:0]                     RDATA,
  output asr_pkg::asr_analog_sel_t             ANALOG_SEL,
  output logic                                 ANALOG_FREQ_SRC,
  output logic                                 DIR_REVERSE,
  output logic                                 MOTOR_EN,
  output logic                                 TRIP,
  output logic                                 ALARM,
  output logic                                 DRIVE_RESET,
  output logic                                 RESTART,
  output logic                                 RESTART_MATCH,
  output logic                                 PANEL_ERR,
  output logic                                 IRQ
);
  import asr_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [NUM_TERM-1:0] term_match(
    input logic [NUM_TERM*FN_W-1:0] funcs,
    input logic [FN_W-1:0]          code
  );
    logic [NUM_TERM-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      m[i] = (funcs[i*FN_W +: FN_W] == code);
    end
    return m;
  endfunction

  // ==========================================================
  // Registers and state
  logic [NUM_TERM*FN_W-1:0] term_func;
  logic [NUM_TERM-1:0]      term_nc;
  logic [7:0]               settings;
  logic [IRQ_W-1:0]         irq_stat;
  logic [IRQ_W-1:0]         irq_mask;
  logic [IRQ_W-1:0]         irq_ev;
  asr_rs_state_t            state;
  asr_rs_state_t            next_state;
  logic [7:0]               seq_cnt;
  logic                     pu_window;
  logic [NUM_PIN-1:0]       pin_db;
  logic [NUM_TERM-1:0]      at_mask;
  logic [NUM_TERM-1:0]      rs_mask;
  logic [NUM_TERM-1:0]      nc_eff;
  logic [NUM_TERM-1:0]      lvl;
  logic                     at_on;
  logic                     rs_on;
  logic                     fwd_on;
  logic                     rev_on;
  logic                     qual_done;
  logic                     panel_done;
  logic                     pins_settled;
  logic                     seq_end;
  logic                     alarm_clr;
  logic                     nc_refused;
  logic [1:0]               pair;
  logic [1:0]               pol;
  logic                     use_current;
  logic                     wr_nc;

  // ==========================================================
  // Terminal conditioning
  asr_debounce #(
    .WIDTH (NUM_PIN),
    .CYC   (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   ({REV_CMD_IN, FWD_CMD_IN, TERM_IN}),
    .dout  (pin_db)
  );

  assign at_mask = term_match(term_func, FN_ANALOG_SEL);
  assign rs_mask = term_match(term_func, FN_RESET);
  assign nc_eff  = term_nc & ~rs_mask;
  assign lvl     = pin_db[NUM_TERM-1:0] ^ nc_eff;
  assign at_on   = |(lvl & at_mask);
  assign rs_on   = |(lvl & rs_mask);
  assign fwd_on  = pin_db[NUM_TERM];
  assign rev_on  = pin_db[NUM_TERM+1];
  assign pair    = settings[SET_PAIR_LSB +: 2];
  assign pol     = settings[SET_POL_LSB +: 2];
  assign use_current = at_on && (pair == PAIR_CURRENT);

  // ==========================================================
  // Analog pair and polarity selection
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ANALOG_SEL      <= '0;
      ANALOG_FREQ_SRC <= 1'b0;
      DIR_REVERSE     <= 1'b0;
    end else begin
      ANALOG_SEL.current <= use_current;
      ANALOG_SEL.volt2   <= at_on && (pair == PAIR_VOLT2);
      ANALOG_SEL.volt1   <= !at_on || ((pair != PAIR_CURRENT) &&
                            (pair != PAIR_VOLT2));
      ANALOG_SEL.bipolar <= !use_current &&
                            (pol != POL_UNIPOLAR);
      ANALOG_FREQ_SRC    <= settings[SET_FSRC_LSB +: 2] ==
                            FSRC_ANALOG;
      if (!use_current && (pol != POL_UNIPOLAR)) begin
        DIR_REVERSE <= ANALOG_NEG;
      end else begin
        DIR_REVERSE <= rev_on && !fwd_on;
      end
    end
  end

  // ==========================================================
  // Reset pulse qualification
  asr_hold_timer #(
    .CYC   (RS_MIN_CYCLES)
  ) u_qual (
    .clk   (CLK),
    .rst_n (rst_n),
    .run   ((state == ST_HELD) && rs_on),
    .done  (qual_done)
  );

  assign seq_end   = (state == ST_SEQ) &&
                     (seq_cnt == 8'(SEQ_CYCLES - 1));
  assign alarm_clr = (state == ST_HELD) && qual_done;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rs_on) begin
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        if (!rs_on) begin
          next_state = ST_IDLE;
        end else if (qual_done) begin
          if (!settings[SET_EDGE_BIT]) begin
            next_state = ST_SEQ;
          end else begin
            next_state = ST_WAIT_REL;
          end
        end
      end
      ST_WAIT_REL: begin
        if (!rs_on) begin
          if (settings[SET_EDGE_BIT]) begin
            next_state = ST_SEQ;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_SEQ: begin
        if (seq_end) begin
          next_state = rs_on ? ST_WAIT_REL : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Power-up starts in the reset sequence
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SEQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      seq_cnt <= 8'h00;
    end else if (state == ST_SEQ && !seq_end) begin
      seq_cnt <= seq_cnt + 8'h01;
    end else begin
      seq_cnt <= 8'h00;
    end
  end

  // ==========================================================
  // Drive state outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TRIP        <= 1'b0;
      ALARM       <= 1'b0;
      DRIVE_RESET <= 1'b0;
      MOTOR_EN    <= 1'b0;
      RESTART     <= 1'b0;
    end else begin
      if (TRIP_EVENT) begin
        TRIP <= 1'b1;
      end else if (state == ST_SEQ) begin
        TRIP <= 1'b0;
      end
      if (TRIP_EVENT) begin
        ALARM <= 1'b1;
      end else if (alarm_clr || state == ST_SEQ) begin
        ALARM <= 1'b0;
      end
      DRIVE_RESET <= (next_state == ST_SEQ);
      MOTOR_EN    <= RUN_CMD && !TRIP && !TRIP_EVENT && !rs_on &&
                     (next_state != ST_SEQ);
      RESTART     <= seq_end && RUN_CMD;
    end
  end

  assign RESTART_MATCH = settings[SET_RESTART_BIT];

  // ==========================================================
  // Reset held from power-up
  asr_hold_timer #(
    .CYC   (PANEL_CYCLES)
  ) u_panel (
    .clk   (CLK),
    .rst_n (rst_n),
    .run   (pu_window && rs_on),
    .done  (panel_done)
  );

  // Pins settle before the power-up hold window may close
  asr_hold_timer #(
    .CYC   (DEBOUNCE_CYCLES + 3)
  ) u_settle (
    .clk   (CLK),
    .rst_n (rst_n),
    .run   (rst_n),
    .done  (pins_settled)
  );

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pu_window <= 1'b1;
      PANEL_ERR <= 1'b0;
    end else begin
      if (pins_settled && !rs_on) begin
        pu_window <= 1'b0;
      end
      if (panel_done) begin
        PANEL_ERR <= 1'b1;
      end else if (!rs_on && KEY_PRESS) begin
        PANEL_ERR <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register bus
  assign wr_nc      = WR && (ADDR == REG_TERM_NC);
  assign nc_refused = wr_nc &&
                      |(WDATA[NUM_TERM-1:0] & rs_mask);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      term_func <= TERM_FUNC_RST;
      term_nc   <= TERM_NC_RST;
      settings  <= SETTINGS_RST;
      irq_mask  <= '0;
    end else if (WR) begin
      case (ADDR)
        REG_TERM_FUNC: term_func <= WDATA[NUM_TERM*FN_W-1:0];
        REG_TERM_NC:   term_nc   <= WDATA[NUM_TERM-1:0] & ~rs_mask;
        REG_SETTINGS:  settings  <= WDATA[7:0];
        REG_IRQ_MASK:  irq_mask  <= WDATA[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        REG_TERM_FUNC: RDATA <= 32'(term_func);
        REG_TERM_NC:   RDATA <= 32'(term_nc);
        REG_SETTINGS:  RDATA <= 32'(settings);
        REG_STATUS:    RDATA <= 32'({PANEL_ERR, ALARM, TRIP,
                                     (state == ST_SEQ), rs_on, at_on,
                                     ANALOG_SEL});
        REG_IRQ_STAT:  RDATA <= 32'(irq_stat);
        REG_IRQ_MASK:  RDATA <= 32'(irq_mask);
        default:       RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end

  // ==========================================================
  // Interrupts
  always_comb begin
    irq_ev                 = '0;
    irq_ev[IRQ_RESET_DONE] = seq_end;
    irq_ev[IRQ_PANEL_ERR]  = panel_done && !PANEL_ERR;
    irq_ev[IRQ_NC_REFUSED] = nc_refused;
    irq_ev[IRQ_TRIP]       = TRIP_EVENT;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      IRQ      <= 1'b0;
    end else begin
      if (WR && ADDR == REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~WDATA[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Checks
  int alarm_cnt;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      alarm_cnt <= 0;
    end else if (state == ST_HELD && ALARM) begin
      alarm_cnt <= alarm_cnt + 1;
    end else begin
      alarm_cnt <= 0;
    end
  end

  sel_current_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (at_on && pair == PAIR_CURRENT) |=>
      (ANALOG_SEL.current && !ANALOG_SEL.volt1 && !ANALOG_SEL.volt2))
    else $error("current pair not selected");
  sel_volt2_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (at_on && pair == PAIR_VOLT2) |=>
      (ANALOG_SEL.volt2 && !ANALOG_SEL.current && !ANALOG_SEL.volt1))
    else $error("second voltage pair not selected");
  sel_primary_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    !at_on |=> (ANALOG_SEL.volt1 && !ANALOG_SEL.volt2 &&
                !ANALOG_SEL.current))
    else $error("primary pair not selected");
  bipolar_set_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (!use_current && pol != POL_UNIPOLAR) |=> ANALOG_SEL.bipolar)
    else $error("bipolar not applied");
  current_unipolar_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    use_current |=> (!ANALOG_SEL.bipolar &&
                     DIR_REVERSE == $past(rev_on && !fwd_on)))
    else $error("current input treated as bipolar");
  motor_off_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (rs_on || (state == ST_SEQ && !seq_end)) |=> !MOTOR_EN)
    else $error("motor on during reset");
  short_pulse_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (state == ST_HELD && !rs_on) |=> (state == ST_IDLE && !DRIVE_RESET))
    else $error("short pulse not rejected");
  alarm_time_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    alarm_cnt < ALARM_CYCLES)
    else $error("alarm held too long after reset");
  restart_now_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (seq_end && RUN_CMD && !rs_on && !TRIP_EVENT) |=> RESTART ##1 MOTOR_EN)
    else $error("no restart after reset");
  panel_err_a: assert property (
    @(posedge CLK) disable iff (!rst_n)
    $rose(PANEL_ERR) |-> ($past(pu_window) && !TRIP))
    else $error("panel error outside power-up hold");
endmodule

// [bench/asr_contacts.sv]
// Model of the external control contacts driven by an operator or a PLC
`timescale 1ns/1ps
module asr_contacts (
  input  wire logic       CLK,
  output logic      [4:0] term,
  output logic            fwd,
  output logic            rev
);
  // ==========================================================
  // Contact levels
  initial begin
    term = 5'h00;
    fwd  = 1'b1;
    rev  = 1'b0;
  end

  // Sets one contact, changed just after a clock edge
  task automatic hold(input int t, input logic lvl);
    @(posedge CLK);
    term[t] <= lvl;
  endtask

  // Sets the forward and reverse command contacts
  task automatic dir(input logic f, input logic r);
    @(posedge CLK);
    fwd <= f;
    rev <= r;
  endtask

  // Closes a contact for a number of cycles, then opens it
  task automatic pulse(input int t, input int cyc);
    hold(t, 1'b1);
    repeat (cyc) @(posedge CLK);
    term[t] <= 1'b0;
  endtask
endmodule

// [bench/asr_top_bench.sv]
// Self-checking bench for the analog select and drive reset logic
`timescale 1ns/1ps
module asr_top_bench;
  import asr_pkg::*;
  // ==========================================================
  // Signals
  logic            CLK, RST_N, RUN_CMD, TRIP_EVENT, ANALOG_NEG, WR, RD;
  logic [4:0]      TERM_IN, ADDR;
  logic            FWD_CMD_IN, REV_CMD_IN;
  logic [31:0]     WDATA, RDATA;
  asr_analog_sel_t ANALOG_SEL;
  logic            ANALOG_FREQ_SRC, DIR_REVERSE, MOTOR_EN, TRIP, ALARM;
  logic            DRIVE_RESET, RESTART, PANEL_ERR, IRQ, KEY_PRESS;
  int              error_cnt, comparisons, cyc;

  asr_contacts asr_contacts_i (.CLK(CLK), .term(TERM_IN),
    .fwd(FWD_CMD_IN), .rev(REV_CMD_IN));
  asr_top #(.DEBOUNCE_CYCLES(2), .RS_MIN_CYCLES(20), .ALARM_CYCLES(50),
    .PANEL_CYCLES(40), .SEQ_CYCLES(16)) asr_top_i (
    .CLK(CLK), .RST_N(RST_N), .TERM_IN(TERM_IN), .FWD_CMD_IN(FWD_CMD_IN),
    .REV_CMD_IN(REV_CMD_IN), .RUN_CMD(RUN_CMD), .TRIP_EVENT(TRIP_EVENT),
    .ANALOG_NEG(ANALOG_NEG), .KEY_PRESS(KEY_PRESS), .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ANALOG_SEL(ANALOG_SEL),
    .ANALOG_FREQ_SRC(ANALOG_FREQ_SRC), .DIR_REVERSE(DIR_REVERSE),
    .MOTOR_EN(MOTOR_EN), .TRIP(TRIP), .ALARM(ALARM),
    .DRIVE_RESET(DRIVE_RESET), .RESTART(RESTART), .RESTART_MATCH(),
    .PANEL_ERR(PANEL_ERR), .IRQ(IRQ));

  // ==========================================================
  // Clock and timeout
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic key;
    @(posedge CLK);
    KEY_PRESS <= 1'b1;
    @(posedge CLK);
    KEY_PRESS <= 1'b0;
    tick(1);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_powerup;
    int i;
    for (i = 0; i < 10 && DRIVE_RESET !== 1'b1; i++) tick(1);
    chk("seq_at_powerup", 1, DRIVE_RESET);
    chk("motor_off", 0, MOTOR_EN);
    for (i = 0; i < 30 && DRIVE_RESET !== 1'b0; i++) tick(1);
    chk("seq_ends", 0, DRIVE_RESET);
    $display("test powerup done");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rd(REG_SETTINGS, d);
    chk("settings_rst", 32'h10, d);
    chk("freq_src", 1, ANALOG_FREQ_SRC);
    rd(5'h1c, d);
    chk("unmapped", 0, d);
    $display("test regs done");
  endtask

  task automatic t_analog;
    logic [3:0] nib[4] = '{4'h4, 4'h5, 4'h8, 4'h1};
    logic       at[4]  = '{1, 1, 0, 0};
    logic [3:0] exp[4] = '{4'b1000, 4'b0101, 4'b0011, 4'b0010};
    for (int k = 0; k < 4; k++) begin
      wr(REG_TERM_FUNC, (32'h10 << (5 * k)) | 32'h1200000);
      wr(REG_SETTINGS, {24'h0, 4'h1, nib[k]});
      asr_contacts_i.hold(k, at[k]);
      tick(10);
      chk("analog_sel", exp[k], ANALOG_SEL);
      chk("analog_sel", exp[k], ANALOG_SEL);
      if (k == 0) begin
        chk("dir_current", 0, DIR_REVERSE);
        asr_contacts_i.dir(1'b0, 1'b1);
        tick(10);
        chk("dir_command", 1, DIR_REVERSE);
        asr_contacts_i.dir(1'b1, 1'b0);
      end
      if (k == 1) begin
        chk("dir_negative", 1, DIR_REVERSE);
        ANALOG_NEG <= 1'b0;
        tick(2);
        chk("dir_positive", 0, DIR_REVERSE);
        ANALOG_NEG <= 1'b1;
      end
      asr_contacts_i.hold(k, 1'b0);
    end
    $display("test analog done");
  endtask

  task automatic t_reset(input logic trailing);
    int ta, rc;
    logic rs, rs2, bad;
    ta = 99; rc = 0; rs = 0; rs2 = 0; bad = 0;
    wr(REG_SETTINGS, 32'h10 | (32'(trailing) << 6));
    @(posedge CLK);
    TRIP_EVENT <= 1'b1;
    @(posedge CLK);
    TRIP_EVENT <= 1'b0;
    asr_contacts_i.pulse(4, 10);
    tick(30);
    chk("short_pulse", 1, TRIP);
    asr_contacts_i.hold(4, 1'b1);
    for (int i = 1; i <= 80; i++) begin
      if (i == 41) asr_contacts_i.hold(4, 1'b0);
      tick(1);
      if (ALARM === 1'b0 && ta == 99) ta = i;
      if (i <= 40) rs |= DRIVE_RESET;
      else rs2 |= DRIVE_RESET;
      bad |= DRIVE_RESET & MOTOR_EN;
      rc += int'(RESTART === 1'b1);
    end
    chk("alarm_bound", 1, ta <= 50);
    chk("seq_in_hold", !trailing, rs);
    if (trailing) chk("seq_at_release", 1, rs2);
    chk("trip_clear", 0, TRIP);
    chk("motor_off", 0, bad);
    chk("restart", 1, rc);
    $display("test reset done");
  endtask

  task automatic t_irq;
    logic [31:0] d;
    wr(REG_TERM_NC, 32'h11);
    rd(REG_TERM_NC, d);
    chk("nc_refused", 32'h01, d);
    rd(REG_IRQ_STAT, d);
    chk("nc_irq", 1, d[IRQ_NC_REFUSED]);
    wr(REG_IRQ_MASK, 32'h0f);
    tick(2);
    chk("irq_on", 1, IRQ);
    wr(REG_IRQ_MASK, 32'h00);
    tick(2);
    chk("irq_mask", 0, IRQ);
    wr(REG_IRQ_MASK, 32'h0f);
    wr(REG_IRQ_STAT, 32'h0f);
    rd(REG_IRQ_STAT, d);
    chk("irq_clear", 0, d);
    chk("irq_low", 0, IRQ);
    $display("test irq done");
  endtask

  task automatic t_panel;
    logic [31:0] d;
    asr_contacts_i.hold(4, 1'b1);
    RST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    t_powerup();
    tick(40);
    chk("panel_err", 1, PANEL_ERR);
    chk("no_fault", 0, TRIP);
    rd(REG_IRQ_STAT, d);
    chk("panel_irq", 1, d[IRQ_PANEL_ERR]);
    asr_contacts_i.hold(4, 1'b0);
    tick(10);
    chk("err_stays", 1, PANEL_ERR);
    key();
    chk("key_clear", 0, PANEL_ERR);
    $display("test panel done");
  endtask

  // ==========================================================
  // Verdict
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    CLK = 0; RST_N = 0; RUN_CMD = 0; TRIP_EVENT = 0; ANALOG_NEG = 1;
    WR = 0; RD = 0; ADDR = 5'h00; WDATA = 32'h0; KEY_PRESS = 0;
    error_cnt = 0; comparisons = 0; cyc = 0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    t_powerup();
    t_regs();
    t_analog();
    RUN_CMD <= 1'b1;
    t_reset(1'b0);
    t_reset(1'b1);
    t_irq();
    t_panel();
    tally_and_finish();
  end
endmodule
